// ==== hdl/sleep_ctrl.sv ====
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
// Functional notes
// [RQ1] sleep happens only when sleep enable is one and sleep executes
// [RQ2] idle stops core and flash clocks, rest keep running
// [RQ3] noise mode also stops the I/O clock; converter clock runs
// [RQ4] power-down halts all clocks and the oscillator
// [RQ5] standby equals power-down but the oscillator keeps running; here standby does not auto-disable the comparator
// [RQ6] idle wakes on any enabled interrupt
// [RQ7] deeper modes wake on external irq zero only when level-triggered
// [RQ8] power-down and standby wake on watchdog, level irq zero, pin change
// [RQ9] interrupt wake stalls core four cycles after start-up, then resumes
// [RQ10] register file and static memory untouched by sleep
// [RQ11] reset during sleep wakes device to reset vector
// [RQ12] level wake source must hold its level long enough
// [RQ13] converter enabled: idle or noise entry starts a conversion
// [RQ14] stopped peripheral is frozen, its registers inaccessible
// [RQ15] clearing a stop bit restarts the clock, state kept
// [RQ16] peripheral stop bits act in active and idle operation
// [RQ17] power-down disables the comparator automatically
// [RQ18] comparator on internal reference keeps reference on in sleep
// [RQ19] converter stays enabled in sleep; re-enable needs extended conversion
// [RQ20] reference enabled when comparator or converter needs it
// [RQ21] enabled watchdog keeps running in every sleep mode
// [RQ22] gated I/O clock disables inputs except wake-up detectors
// [RQ23] control: enable bit 0, mode bits 3:1, four codes reserved
// [RQ24] stop register: bit 2 serial, bit 1 converter, bit 0 timer
// [RQ25] sleep with enable low or reserved mode acts as no-op

module sleep_ctrl
   import sleep_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst_b,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // core side
   input  wire logic              sleep_instr,
   input  wire logic              irq_any,
   input  wire logic              irq_ext0,
   input  wire logic              irq_conv,
   input  wire logic              irq_vlm,
   input  wire logic              wdt_event,
   input  wire logic              conv_sw_start,
   input  wire logic              ext0_pin_b,
   input  wire logic              pin_change,
   output logic                   core_stall,
   output logic                   resume_irq,
   // clock domain enables
   output logic                   core_clk_en,
   output logic                   flash_clk_en,
   output logic                   io_clk_en,
   output logic                   conv_clk_en,
   output logic                   osc_en,
   output logic                   serial_clk_en,
   output logic                   conv_gate_clk_en,
   output logic                   timer_clk_en,
   output logic [2:0]             periph_access_en,
   // analog and misc
   output logic                   conv_start,
   output logic                   conv_extended,
   output logic                   comparator_disable,
   output logic                   vref_en,
   output logic                   wdt_run,
   output logic                   digital_in_en,
   output logic                   wake_in_en
);

   logic [3:0]   sleep_control_reg_r;
   logic [2:0]   power_gate_reg_r;
   logic [5:0]   aux_ctrl_r;
   logic         nop_seen_r;
   logic [2:0]   act_mode_r;
   logic [2:0]   cnt_r;
   logic         conv_was_off_r;
   sleep_state_t state_r;
   sleep_state_t state_nxt;

   logic [1:0]   pins_sync;
   logic         ext0_low;
   logic         pc_seen;

   // pins come from outside the clock domain
   bit_sync #(.W(2)) u_pin_sync (
      .mclk  (mclk),
      .rst_b (rst_b),
      .din   ({pin_change, ~ext0_pin_b}),
      .dout  (pins_sync)
   );
   assign ext0_low = pins_sync[0];
   assign pc_seen  = pins_sync[1];

   // apb decode
   logic [7:0] idx;
   logic       setup_ph;
   logic       wr_ev;
   logic       hit;
   assign idx      = paddr[ADDR_W-1:2];
   assign setup_ph = psel & ~penable;
   assign wr_ev    = psel & penable & pready & pwrite & ~pslverr;
   assign hit      = (idx == SLEEP_CTRL_IDX) | (idx == POWER_GATE_IDX) |
                     (idx == AUX_CTRL_IDX) | (idx == SLEEP_STAT_IDX);

   // mode decode
   logic [2:0] sel_mode;
   logic       mode_legal;
   logic       sleep_go;
   assign sel_mode   = sleep_control_reg_r[SM_MSB:SM_LSB];
   assign mode_legal = (sel_mode == MODE_IDLE) | (sel_mode == MODE_NOISE) |
                       (sel_mode == MODE_PDOWN) |
                       (sel_mode == MODE_STANDBY);              // see [RQ23]
   // both enable and instruction needed; else a plain no-op
   assign sleep_go   = sleep_instr & sleep_control_reg_r[SE_BIT] &
                       mode_legal & (state_r == ST_ACTIVE);     // see [RQ1]

   // wake decode per active mode
   logic ext0_lvl_wake;
   logic wake;
   assign ext0_lvl_wake = ext0_low & aux_ctrl_r[AUX_EXT0_LEVEL]; // see [RQ7]
   always_comb begin
      unique case (act_mode_r)
         MODE_IDLE:  wake = irq_any | irq_ext0 | irq_conv | irq_vlm |
                            wdt_event | pc_seen;                // see [RQ6]
         MODE_NOISE: wake = ext0_lvl_wake | pc_seen | irq_conv |
                            irq_vlm | wdt_event;                // see [RQ7]
         default:    wake = ext0_lvl_wake | pc_seen |
                            wdt_event;                          // see [RQ8]
      endcase
   end

   // sleep sequencer next state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_ACTIVE:
            if (sleep_go) begin
               state_nxt = ST_SLEEP;
            end
         ST_SLEEP:
            if (wake) begin
               // only power-down has a stopped oscillator to restart
               if (act_mode_r == MODE_PDOWN) begin
                  state_nxt = ST_OSC_START;                     // see [RQ5]
               end else begin
                  state_nxt = ST_STALL;
               end
            end
         ST_OSC_START:
            if (cnt_r == 3'h1) begin
               state_nxt = ST_STALL;
            end
         ST_STALL:
            if (cnt_r == 3'h1) begin
               state_nxt = ST_ACTIVE;
            end
      endcase
   end

   // state; reset is async so a reset in sleep lands in active
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_ACTIVE;                                  // see [RQ11]
      end else begin
         state_r <= state_nxt;
      end
   end

   // captured mode, held for the whole sleep
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         act_mode_r <= MODE_IDLE;
      end else if (sleep_go) begin
         act_mode_r <= sel_mode;
      end
   end

   // start-up and stall counter
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= 3'h0;
      end else if (state_r == ST_SLEEP && state_nxt == ST_OSC_START) begin
         cnt_r <= OSC_START_CYC;
      end else if (state_r != ST_STALL && state_nxt == ST_STALL) begin
         cnt_r <= WAKE_STALL_CYC;                               // see [RQ9]
      end else if (cnt_r != 3'h0) begin
         cnt_r <= cnt_r - 3'h1;
      end
   end

   // sleep control register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sleep_control_reg_r <= SLEEP_CTRL_RST;
      end else if (wr_ev && idx == SLEEP_CTRL_IDX) begin
         sleep_control_reg_r <= pwdata[3:0];                    // see [RQ23]
      end
   end

   // peripheral stop bits
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         power_gate_reg_r <= POWER_GATE_RST;
      end else if (wr_ev && idx == POWER_GATE_IDX) begin
         power_gate_reg_r <= pwdata[2:0];                       // see [RQ24]
      end
   end

   // analog and watchdog enables
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         aux_ctrl_r <= AUX_CTRL_RST;
      end else if (wr_ev && idx == AUX_CTRL_IDX) begin
         aux_ctrl_r <= pwdata[5:0];
      end
   end

   // sticky no-op flag; a new no-op wins over a clearing write
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         nop_seen_r <= 1'b0;
      end else if (sleep_instr && state_r == ST_ACTIVE && !sleep_go) begin
         nop_seen_r <= 1'b1;                                    // see [RQ25]
      end else if (wr_ev && idx == SLEEP_STAT_IDX &&
                   pwdata[STAT_NOP_BIT]) begin
         nop_seen_r <= 1'b0;
      end
   end

   // read mux, registered in the setup cycle
   logic [31:0] rd_val;
   always_comb begin
      rd_val = 32'h0;
      unique case (idx)
         SLEEP_CTRL_IDX: rd_val[3:0] = sleep_control_reg_r;
         POWER_GATE_IDX: rd_val[2:0] = power_gate_reg_r;
         AUX_CTRL_IDX:   rd_val[5:0] = aux_ctrl_r;
         SLEEP_STAT_IDX: begin
            rd_val[1:0]          = state_r;
            rd_val[4:2]          = act_mode_r;
            rd_val[STAT_NOP_BIT] = nop_seen_r;
         end
         default:        rd_val = 32'h0;
      endcase
   end

   // no wait states: ready rises the cycle after setup
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else if (setup_ph) begin
         pready  <= 1'b1;
         pslverr <= ~hit;
         prdata  <= pwrite ? 32'h0 : rd_val;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
   end

   // domain run terms for next cycle
   logic       asleep_nxt;
   logic       run_core;
   logic       run_io;
   logic       run_conv;
   logic       run_osc;
   assign asleep_nxt = (state_nxt != ST_ACTIVE);
   // mode for the coming cycle; sleep_go loads it this edge
   logic [2:0] mode_nxt;
   assign mode_nxt = sleep_go ? sel_mode : act_mode_r;
   assign run_core = ~asleep_nxt;                               // see [RQ2]
   assign run_io   = ~asleep_nxt | (mode_nxt == MODE_IDLE);     // see [RQ3]
   assign run_conv = ~asleep_nxt | (mode_nxt == MODE_IDLE) |
                     (mode_nxt == MODE_NOISE);                  // see [RQ3]
   // standby keeps the oscillator; power-down stops it until restart
   assign run_osc  = ~asleep_nxt | (mode_nxt != MODE_PDOWN) |
                     (state_nxt == ST_OSC_START) |
                     (state_nxt == ST_STALL);                   // see [RQ4]

   // clock domain gates
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         core_clk_en  <= 1'b1;
         flash_clk_en <= 1'b1;
         io_clk_en    <= 1'b1;
         conv_clk_en  <= 1'b1;
         osc_en       <= 1'b1;
      end else begin
         core_clk_en  <= run_core;                              // see [RQ2]
         flash_clk_en <= run_core;                              // see [RQ2]
         io_clk_en    <= run_io;                                // see [RQ3]
         conv_clk_en  <= run_conv;                              // see [RQ4]
         osc_en       <= run_osc;                               // see [RQ5]
      end
   end

   // per-peripheral gates ride on top of the domain gates, so they
   // only matter while the parent clock still runs
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         serial_clk_en    <= 1'b1;
         conv_gate_clk_en <= 1'b1;
         timer_clk_en     <= 1'b1;
         periph_access_en <= 3'h7;
      end else begin
         serial_clk_en    <= run_io &
                             ~power_gate_reg_r[SERIAL_GATE_BIT]; // see [RQ16]
         conv_gate_clk_en <= run_conv &
                             ~power_gate_reg_r[CONV_GATE_BIT];   // see [RQ15]
         timer_clk_en     <= run_io &
                             ~power_gate_reg_r[TIMER_GATE_BIT];  // see [RQ16]
         // stopped block keeps its state; its clock and its access are cut
         periph_access_en <= ~power_gate_reg_r;                 // see [RQ14]
      end
   end

   // core handshake; no memory is touched here, contents survive
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         core_stall <= 1'b0;
         resume_irq <= 1'b0;
      end else begin
         core_stall <= asleep_nxt;                              // see [RQ10]
         resume_irq <= (state_r == ST_STALL) &&
                       (state_nxt == ST_ACTIVE);                // see [RQ9]
      end
   end

   // conversion start on quiet-mode entry
   logic entering_quiet;
   assign entering_quiet = sleep_go & ((sel_mode == MODE_IDLE) |
                                       (sel_mode == MODE_NOISE));
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         conv_start <= 1'b0;
      end else begin
         conv_start <= entering_quiet & aux_ctrl_r[AUX_CONV_EN]; // see [RQ13]
      end
   end

   // extended conversion pending after converter off then on
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         conv_was_off_r <= 1'b1;
         conv_extended  <= 1'b1;
      end else begin
         conv_was_off_r <= ~aux_ctrl_r[AUX_CONV_EN];
         if (conv_was_off_r && aux_ctrl_r[AUX_CONV_EN]) begin
            conv_extended <= 1'b1;                              // see [RQ19]
         end else if (conv_start || conv_sw_start) begin
            conv_extended <= 1'b0;
         end
      end
   end

   // analog, watchdog and input buffer enables
   logic cmp_sw_on;
   logic pdown_asleep;
   assign cmp_sw_on    = ~aux_ctrl_r[AUX_CMP_OFF];
   assign pdown_asleep = asleep_nxt & (mode_nxt == MODE_PDOWN);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         comparator_disable <= 1'b0;
         vref_en            <= 1'b0;
         wdt_run            <= 1'b0;
         digital_in_en      <= 1'b1;
         wake_in_en         <= 1'b1;
      end else begin
         comparator_disable <= ~cmp_sw_on | pdown_asleep;       // see [RQ17]
         // reference follows software enables, not the sleep mode
         vref_en            <= (cmp_sw_on & aux_ctrl_r[AUX_CMP_REF]) |
                               (aux_ctrl_r[AUX_CONV_EN] &
                                aux_ctrl_r[AUX_CONV_REF]); // see [RQ18] [RQ20]
         wdt_run            <= aux_ctrl_r[AUX_WDT_EN];          // see [RQ21]
         digital_in_en      <= run_io;                          // see [RQ22]
         wake_in_en         <= 1'b1;                            // see [RQ22]
      end
   end

endmodule

// ==== hdl/sleep_pkg.sv ====
package sleep_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] SLEEP_CTRL_IDX   = 8'h3a;
   localparam logic [7:0] POWER_GATE_IDX   = 8'h35;
   localparam logic [7:0] AUX_CTRL_IDX     = 8'h3c;
   localparam logic [7:0] SLEEP_STAT_IDX   = 8'h3d;
   localparam int         ADDR_W           = 10;

   // sleep_control_reg fields
   localparam int         SE_BIT           = 0;
   localparam int         SM_LSB           = 1;
   localparam int         SM_MSB           = 3;
   localparam logic [3:0] SLEEP_CTRL_RST   = 4'h0;

   // sleep_mode_field codes
   localparam logic [2:0] MODE_IDLE        = 3'h0;
   localparam logic [2:0] MODE_NOISE       = 3'h1;
   localparam logic [2:0] MODE_PDOWN       = 3'h2;
   localparam logic [2:0] MODE_STANDBY     = 3'h4;

   // power_gate_reg fields
   localparam int         TIMER_GATE_BIT   = 0;
   localparam int         CONV_GATE_BIT    = 1;
   localparam int         SERIAL_GATE_BIT  = 2;
   localparam logic [2:0] POWER_GATE_RST   = 3'h0;

   // aux control fields
   localparam int         AUX_CONV_EN      = 0;
   localparam int         AUX_CONV_REF     = 1;
   localparam int         AUX_CMP_OFF      = 2;
   localparam int         AUX_CMP_REF      = 3;
   localparam int         AUX_WDT_EN       = 4;
   localparam int         AUX_EXT0_LEVEL   = 5;
   localparam logic [5:0] AUX_CTRL_RST     = 6'h00;

   // status fields
   localparam int         STAT_NOP_BIT     = 5;

   // timing, in main clock cycles
   localparam logic [2:0] OSC_START_CYC    = 3'h6;
   localparam logic [2:0] WAKE_STALL_CYC   = 3'h4;

   typedef enum logic [1:0] {
      ST_ACTIVE,
      ST_SLEEP,
      ST_OSC_START,
      ST_STALL
   } sleep_state_t;

endpackage

// ==== hdl/bit_sync.sv ====
`timescale 1ns/1ps

// two-stage synchroniser for asynchronous levels
module bit_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= '0;
         dout   <= '0;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end

endmodule

// ==== bench/sleep_ctrl_assertions.sv ====
`timescale 1ns/1ps

// watches the controller from its pins only
module sleep_ctrl_chk (
   input wire logic       mclk,
   input wire logic       rst_b,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       core_stall,
   input wire logic       resume_irq,
   input wire logic       core_clk_en,
   input wire logic       flash_clk_en,
   input wire logic       io_clk_en,
   input wire logic       conv_clk_en,
   input wire logic       osc_en,
   input wire logic       serial_clk_en,
   input wire logic       conv_gate_clk_en,
   input wire logic       timer_clk_en,
   input wire logic [2:0] periph_access_en,
   input wire logic       conv_start,
   input wire logic       comparator_disable,
   input wire logic       digital_in_en,
   input wire logic       wake_in_en
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);

   property p_core_off;
      core_stall |-> !core_clk_en && !flash_clk_en;
   endproperty
   a_core_off: assert property (p_core_off)
      else $error("core clock runs while stalled");
   // oscillator off only in power-down, so everything else is down too
   property p_pdown;
      !osc_en |-> !io_clk_en && !conv_clk_en && comparator_disable;
   endproperty
   a_pdown: assert property (p_pdown)
      else $error("clock or comparator alive with oscillator off");
   property p_noise;
      !conv_clk_en |-> !io_clk_en;
   endproperty
   a_noise: assert property (p_noise)
      else $error("io clock runs without converter clock");
   // stall must have lasted at least four cycles before resume
   property p_resume;
      resume_irq |-> core_clk_en && $past(core_stall, 1)
         && $past(core_stall, 4);
   endproperty
   a_resume: assert property (p_resume)
      else $error("resume without four stall cycles");
   property p_inputs;
      !io_clk_en |-> !digital_in_en && wake_in_en;
   endproperty
   a_inputs: assert property (p_inputs)
      else $error("input buffers wrong with io clock off");
   property p_gate;
      (serial_clk_en |-> io_clk_en && periph_access_en[2])
      and (conv_gate_clk_en |-> conv_clk_en && periph_access_en[1])
      and (timer_clk_en |-> periph_access_en[0]);
   endproperty
   a_gate: assert property (p_gate)
      else $error("peripheral clock runs while stopped");
   property p_conv_start;
      conv_start |-> core_stall && conv_clk_en ##1 !conv_start;
   endproperty
   a_conv_start: assert property (p_conv_start)
      else $error("conversion start outside sleep entry");
   property p_apb;
      psel && !penable |=> pready ##1 !pready;
   endproperty
   a_apb: assert property (p_apb)
      else $error("apb answer not a single access cycle");

   c_resume: cover property (resume_irq);
   c_pdown: cover property (!osc_en);
   c_conv: cover property (conv_start);
endmodule

bind sleep_ctrl sleep_ctrl_chk i_chk (
   .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
   .pready(pready), .core_stall(core_stall), .resume_irq(resume_irq),
   .core_clk_en(core_clk_en), .flash_clk_en(flash_clk_en),
   .io_clk_en(io_clk_en), .conv_clk_en(conv_clk_en), .osc_en(osc_en),
   .serial_clk_en(serial_clk_en), .conv_gate_clk_en(conv_gate_clk_en),
   .timer_clk_en(timer_clk_en), .periph_access_en(periph_access_en),
   .conv_start(conv_start), .comparator_disable(comparator_disable),
   .digital_in_en(digital_in_en), .wake_in_en(wake_in_en)
);

// ==== bench/core_model.sv ====
`timescale 1ns/1ps

// core side: issues the sleep instruction and counts resumes
module core_model (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       go,
   input  wire logic       core_stall,
   input  wire logic       resume_irq,
   output logic            sleep_instr,
   output logic [7:0]      n_resume
);
   // a stalled core executes nothing, so no sleep while held
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sleep_instr <= 1'b0;
      end else begin
         sleep_instr <= go && !core_stall;
      end
   end
   // each resume means the core services its irq and goes on
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         n_resume <= 8'h00;
      end else if (resume_irq) begin
         n_resume <= n_resume + 8'h01;
      end
   end
endmodule

// ==== bench/tb_sleep_ctrl.sv ====
`timescale 1ns/1ps

module tb_sleep_ctrl;
   import sleep_pkg::*;
   logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, sleep_instr, go = 0;
   logic irq_any = 0, wdt_event = 0, ext0_pin_b = 1, pin_change = 0;
   logic core_stall, resume_irq, core_clk_en, flash_clk_en, io_clk_en;
   logic conv_clk_en, osc_en, serial_clk_en, conv_gate_clk_en;
   logic timer_clk_en, conv_start, conv_extended, comparator_disable;
   logic vref_en, wdt_run, digital_in_en, wake_in_en;
   logic [2:0] periph_access_en;
   logic [7:0] n_resume;
   int num_errors = 0, n_tests = 0;

   always #4 mclk = ~mclk;

   sleep_ctrl i_dut (.mclk(mclk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sleep_instr(sleep_instr), .irq_any(irq_any), .irq_ext0(1'b0),
      .irq_conv(1'b0), .irq_vlm(1'b0), .wdt_event(wdt_event),
      .conv_sw_start(1'b0), .ext0_pin_b(ext0_pin_b),
      .pin_change(pin_change), .core_stall(core_stall),
      .resume_irq(resume_irq), .core_clk_en(core_clk_en),
      .flash_clk_en(flash_clk_en), .io_clk_en(io_clk_en),
      .conv_clk_en(conv_clk_en), .osc_en(osc_en),
      .serial_clk_en(serial_clk_en), .conv_gate_clk_en(conv_gate_clk_en),
      .timer_clk_en(timer_clk_en), .periph_access_en(periph_access_en),
      .conv_start(conv_start), .conv_extended(conv_extended),
      .comparator_disable(comparator_disable), .vref_en(vref_en),
      .wdt_run(wdt_run), .digital_in_en(digital_in_en),
      .wake_in_en(wake_in_en));
   core_model i_core (.mclk(mclk), .rst_b(rst_b), .go(go),
      .core_stall(core_stall), .resume_irq(resume_irq),
      .sleep_instr(sleep_instr), .n_resume(n_resume));

   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(logic w, logic [7:0] i, logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge mclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic wr(logic [7:0] i, logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1, i, d, r, e);
   endtask
   task automatic rdc(string n, logic [7:0] i, logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(0, i, 32'h0, r, e);
      chk(n, x, r);
   endtask
   task automatic slp(logic [2:0] m, logic se);
      wr(SLEEP_CTRL_IDX, {28'h0, m, se});
      @(posedge mclk) go <= 1;
      @(posedge mclk) go <= 0;
      repeat (4) @(posedge mclk);
   endtask
   // waits for the core to see a resume, bounded
   task automatic wres();
      int k;
      logic [7:0] c;
      k = 0;
      c = n_resume;
      while (n_resume === c && k < 60) begin
         @(posedge mclk);
         k++;
      end
      chk("resume", 1, n_resume !== c);
      irq_any <= 0; wdt_event <= 0; ext0_pin_b <= 1;
      repeat (2) @(posedge mclk);
   endtask

   task automatic t_reset();
      chk("clk_en", 5'h1f, {core_clk_en, flash_clk_en, io_clk_en,
          conv_clk_en, osc_en});
      chk("conv_ext", 1, conv_extended);
      chk("access", 3'h7, periph_access_en);
      rdc("ctrl_rst", SLEEP_CTRL_IDX, 32'h0);
      rdc("gate_rst", POWER_GATE_IDX, 32'h0);
   endtask
   task automatic t_modes();
      logic [2:0] md[4] = '{MODE_IDLE, MODE_NOISE, MODE_PDOWN, MODE_STANDBY};
      logic [3:0] ck[4] = '{4'he, 4'h6, 4'h1, 4'h2};
      wr(AUX_CTRL_IDX, 32'h11);
      wr(POWER_GATE_IDX, 32'h1);
      for (int i = 0; i < 4; i++) begin
         slp(md[i], 1);
         chk("stall", 1, core_stall);
         chk("dom", ck[i], {io_clk_en, conv_clk_en, osc_en,
             comparator_disable});
         chk("wdt", 1, wdt_run);
         wdt_event <= 1;
         wres();
         rdc("kept", POWER_GATE_IDX, 32'h1);
      end
      wr(POWER_GATE_IDX, 32'h0);
   endtask
   task automatic t_refuse();
      logic [3:0] c[5] = '{4'h4, 4'h7, 4'hb, 4'hd, 4'hf};
      for (int i = 0; i < 5; i++) begin
         slp(c[i][3:1], c[i][0]);
         chk("nop", 0, core_stall);
         // mode field still holds standby from the last real sleep
         rdc("nop_flag", SLEEP_STAT_IDX, 32'h30);
         wr(SLEEP_STAT_IDX, 32'h20);
      end
   endtask
   task automatic t_wake();
      wr(AUX_CTRL_IDX, 32'h10);
      slp(MODE_PDOWN, 1);
      ext0_pin_b <= 0; irq_any <= 1;
      repeat (30) @(posedge mclk);
      chk("edge_nowake", 1, core_stall);
      wr(AUX_CTRL_IDX, 32'h30);
      wres();
      slp(MODE_STANDBY, 1);
      pin_change <= 1;
      wres();
      pin_change <= 0;
      slp(MODE_IDLE, 1);
      irq_any <= 1;
      wres();
   endtask
   task automatic t_gate();
      wr(POWER_GATE_IDX, 32'h5);
      repeat (2) @(posedge mclk);
      chk("gates", 3'h2, {serial_clk_en, conv_gate_clk_en,
          timer_clk_en});
      chk("access", 3'h2, periph_access_en);
      slp(MODE_IDLE, 1);
      chk("idle_gate", 3'h2, {serial_clk_en, conv_gate_clk_en,
          timer_clk_en});
      irq_any <= 1;
      wres();
      wr(POWER_GATE_IDX, 32'h0);
      repeat (2) @(posedge mclk);
      chk("ungate", 3'h7, {serial_clk_en, conv_gate_clk_en,
          timer_clk_en});
      wr(AUX_CTRL_IDX, 32'h03);
      repeat (2) @(posedge mclk);
      chk("vref_on", 1, vref_en);
      wr(AUX_CTRL_IDX, 32'h0);
      repeat (2) @(posedge mclk);
      chk("vref_off", 0, vref_en);
   endtask
   task automatic t_misc();
      logic [31:0] r;
      logic e;
      apb(0, 8'h10, 32'h0, r, e);
      chk("unmapped", 1, e);
      slp(MODE_PDOWN, 1);
      @(posedge mclk) rst_b <= 0;
      @(posedge mclk);
      chk("rst_wake", 2'h1, {core_stall, osc_en});
      rst_b <= 1;
      repeat (2) @(posedge mclk);
      rdc("rst_ctrl", SLEEP_CTRL_IDX, 32'h0);
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #160000;
      num_errors++;
      final_report();
   end
   initial begin
      repeat (3) @(posedge mclk);
      rst_b <= 1;
      @(posedge mclk);
      t_reset();
      t_modes();
      t_refuse();
      t_wake();
      t_gate();
      t_misc();
      final_report();
   end
endmodule
